/* File: rtl/sas_sequencer.sv */
`timescale 1ns/1ps
module sas_sequencer
	import sas_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// system
	input wire logic standby,
	output logic conversion_end_irq,
	// analog front end
	output logic [2:0] analog_sel,
	output logic sample_hold,
	output logic [7:0] tap_code,
	input wire logic comp_in,
	// result stream with two-entry buffer
	output logic res_valid,
	input wire logic res_ready,
	output logic [7:0] res_data
);
	////////////////////////////////////////////////////////////////
	logic [7:0] mode_reg, mode_next;
	logic [7:0] chan_reg, chan_next;
	logic [7:0] conversion_result_reg, conversion_result_next;
	logic [7:0] rdata_reg, rdata_next;
	sas_state_t state_reg, state_next;
	logic [7:0] sar_reg, sar_next;
	logic [7:0] bitmask_reg, bitmask_next;
	logic [7:0] cnt_reg, cnt_next;
	logic irq_reg, irq_next;
	logic sh_reg, sh_next;
	logic [2:0] sel_reg, sel_next;
	logic [2:0] cmp_sync_reg;
	logic cmp_reg, cmp_next;
	logic [7:0] step_len;
	logic wr_mode, wr_chan, wr_any, conv_en;
	logic [7:0] buf0_reg, buf1_reg, buf0_next, buf1_next;
	logic [1:0] cnt_buf_reg, cnt_buf_next;
	logic res_valid_reg, res_valid_next;
	logic push;
	logic load;
	////////////////////////////////////////////////////////////////
	assign wr_mode = reg_wr && (reg_addr == SAS_ADDR_MODE);
	assign wr_chan = reg_wr && (reg_addr == SAS_ADDR_CHAN);
	assign wr_any = wr_mode || wr_chan;
	assign conv_en = mode_reg[SAS_MODE_EN_BIT] && !standby;
	// per-bit step length; prohibited codes fall back to the slowest setting
	always_comb begin
		case (mode_reg[SAS_MODE_FR_LSB +: SAS_MODE_FR_W])
			SAS_FR_144: step_len = 8'((SAS_CYC_144 - SAS_SAMPLE_CYC) >> 3);
			SAS_FR_120: step_len = 8'((SAS_CYC_120 - SAS_SAMPLE_CYC) >> 3);
			SAS_FR_96: step_len = 8'((SAS_CYC_96 - SAS_SAMPLE_CYC) >> 3);
			SAS_FR_72: step_len = 8'((SAS_CYC_72 - SAS_SAMPLE_CYC) >> 3);
			default: step_len = 8'((SAS_CYC_144 - SAS_SAMPLE_CYC) >> 3);
		endcase
	end
	////////////////////////////////////////////////////////////////
	// registers; writes keep only implemented bits
	always_comb begin
		mode_next = mode_reg;
		chan_next = chan_reg;
		if (wr_mode) begin
			mode_next = reg_wdata & SAS_MODE_MASK;
		end
		if (wr_chan) begin
			chan_next = {5'h0_0, reg_wdata[SAS_CHAN_W-1:0]};
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_reg <= SAS_MODE_RST;
			chan_reg <= SAS_CHAN_RST;
		end else begin
			mode_reg <= mode_next;
			chan_reg <= chan_next;
		end
	end
	////////////////////////////////////////////////////////////////
	// comparator arrives from the analog domain: three stages
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cmp_sync_reg <= 3'h0;
			cmp_reg <= 1'b0;
		end else begin
			cmp_sync_reg <= {cmp_sync_reg[1:0], comp_in};
			cmp_reg <= cmp_next;
		end
	end
	assign cmp_next = (cmp_sync_reg[2] == cmp_sync_reg[1]) ? cmp_sync_reg[1] : cmp_reg;
	////////////////////////////////////////////////////////////////
	// sequencer; a register write has precedence over everything
	always_comb begin
		state_next = state_reg;
		sar_next = sar_reg;
		bitmask_next = bitmask_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		sel_next = sel_reg;
		load = 1'b0;
		if (wr_any || !conv_en) begin
			// abort; restart from sample if still enabled after write
			state_next = (mode_next[SAS_MODE_EN_BIT] && !standby) ? SAS_SAMPLE : SAS_IDLE;
			cnt_next = 8'h00;
			sh_next = 1'b0;
			sar_next = 8'h00;
			bitmask_next = 8'h00;
			sel_next = chan_next[SAS_CHAN_W-1:0];
		end else begin
			case (state_reg)
				SAS_IDLE: begin
					state_next = SAS_SAMPLE;
					cnt_next = 8'h00;
					sel_next = chan_reg[SAS_CHAN_W-1:0];
				end
				SAS_SAMPLE: begin
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg == SAS_SAMPLE_CYC - 8'h01) begin
						sh_next = 1'b1;
						state_next = SAS_BITS;
						cnt_next = 8'h00;
						sar_next = SAS_TAP_HALF;
						bitmask_next = SAS_TAP_HALF;
					end
				end
				SAS_BITS: begin
					cnt_next = cnt_reg + 8'h01;
					if (cnt_reg == step_len - 8'h01) begin
						cnt_next = 8'h00;
						// keep trial bit when input at or above tap
						if (!cmp_reg) begin
							sar_next = sar_reg & ~bitmask_reg;
						end
						sar_next = sar_next | (bitmask_reg >> 1);
						bitmask_next = bitmask_reg >> 1;
						if (bitmask_reg[0]) begin
							load = 1'b1;
							state_next = SAS_SAMPLE;
							sh_next = 1'b0;
							sel_next = chan_reg[SAS_CHAN_W-1:0];
						end
					end
				end
				default: state_next = SAS_IDLE;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= SAS_IDLE;
			sar_reg <= 8'h00;
			bitmask_reg <= 8'h00;
			cnt_reg <= 8'h00;
			sh_reg <= 1'b0;
			sel_reg <= 3'h0;
		end else begin
			state_reg <= state_next;
			sar_reg <= sar_next;
			bitmask_reg <= bitmask_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			sel_reg <= sel_next;
		end
	end
	////////////////////////////////////////////////////////////////
	// result load, end pulse and read data; read samples the old value
	always_comb begin
		conversion_result_next = conversion_result_reg;
		rdata_next = 8'h00;
		irq_next = load;
		if (load) begin
			conversion_result_next = sar_next;
		end
		if (reg_rd) begin
			case (reg_addr)
				SAS_ADDR_MODE: rdata_next = mode_reg;
				SAS_ADDR_CHAN: rdata_next = chan_reg;
				SAS_ADDR_RESULT: rdata_next = conversion_result_reg;
				default: rdata_next = 8'h00;
			endcase
		end
	end
	// no reset: the result is undefined after reset
	always_ff @(posedge clk) begin
		conversion_result_reg <= conversion_result_next;
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else begin
			rdata_reg <= rdata_next;
			irq_reg <= irq_next;
		end
	end
	////////////////////////////////////////////////////////////////
	// two-entry result buffer; a pop in the same cycle frees a slot for the new word
	// when full and stalled a new result is dropped, never an old one
	assign push = load && ((cnt_buf_reg != 2'h2) || res_ready);
	always_comb begin
		buf0_next = buf0_reg;
		buf1_next = buf1_reg;
		cnt_buf_next = cnt_buf_reg;
		if (res_valid && res_ready) begin
			buf0_next = buf1_reg;
			cnt_buf_next = cnt_buf_reg - 2'h1;
		end
		if (push) begin
			if (cnt_buf_next == 2'h0) begin
				buf0_next = sar_next;
			end else begin
				buf1_next = sar_next;
			end
			cnt_buf_next = cnt_buf_next + 2'h1;
		end
		res_valid_next = (cnt_buf_next != 2'h0);
	end
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			buf0_reg <= 8'h00;
			buf1_reg <= 8'h00;
			cnt_buf_reg <= 2'h0;
			res_valid_reg <= 1'b0;
		end else begin
			buf0_reg <= buf0_next;
			buf1_reg <= buf1_next;
			cnt_buf_reg <= cnt_buf_next;
			res_valid_reg <= res_valid_next;
		end
	end
	////////////////////////////////////////////////////////////////
	assign reg_rdata = rdata_reg;
	assign conversion_end_irq = irq_reg;
	assign analog_sel = sel_reg;
	assign sample_hold = sh_reg;
	assign tap_code = sar_reg;
	assign res_valid = res_valid_reg;
	assign res_data = buf0_reg;
	////////////////////////////////////////////////////////////////
	AST_RESET_MODE: assert property (@(posedge clk) !rst_n |=> mode_reg == 8'h00)
		else $error("mode not cleared by reset");
	AST_RESET_CHAN: assert property (@(posedge clk) !rst_n |=> analog_sel == 3'h0)
		else $error("channel not cleared by reset");
	AST_WRITE_ABORT: assert property (@(posedge clk) disable iff (!rst_n)
		wr_any |=> !sample_hold && state_reg != SAS_BITS)
		else $error("write did not abort conversion");
	AST_DISABLE_HALT: assert property (@(posedge clk) disable iff (!rst_n)
		wr_mode && !reg_wdata[SAS_MODE_EN_BIT] |=> state_reg == SAS_IDLE)
		else $error("disable write did not halt");
	AST_LOAD_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> conversion_end_irq && conversion_result_reg == $past(sar_next))
		else $error("end request missing after load");
	AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
		load |=> state_reg == SAS_SAMPLE && !sample_hold)
		else $error("no new sample phase after completion");
	AST_WRITE_NO_IRQ: assert property (@(posedge clk) disable iff (!rst_n)
		wr_any |=> !conversion_end_irq)
		else $error("end request raised on write cycle");
	AST_RESULT_STABLE: assert property (@(posedge clk) disable iff (!rst_n)
		!load |=> $stable(conversion_result_reg))
		else $error("result changed without load");
	// standby blocks the end request and leaves the bit phase on the same edge; the state is checked one cycle later
	sequence sas_stop_seq;
		!conversion_end_irq ##1 state_reg != SAS_BITS;
	endsequence : sas_stop_seq
	AST_STANDBY_STOP: assert property (@(posedge clk) disable iff (!rst_n)
		standby |=> sas_stop_seq)
		else $error("converting in standby");
	AST_MSB_TRIAL: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(sample_hold) |-> tap_code == 8'h80)
		else $error("first trial not at half tap");
	AST_READ_OLD: assert property (@(posedge clk) disable iff (!rst_n)
		reg_rd && reg_addr == SAS_ADDR_RESULT |=> reg_rdata == $past(conversion_result_reg))
		else $error("read did not return old result");
endmodule : sas_sequencer

/* File: rtl/sas_pkg.sv */
package sas_pkg;
	// register addresses on the special function bus
	localparam logic [15:0] SAS_ADDR_MODE = 16'hFF80;
	localparam logic [15:0] SAS_ADDR_CHAN = 16'hFF84;
	localparam logic [15:0] SAS_ADDR_RESULT = 16'hFF81;
	// mode register fields
	localparam int SAS_MODE_EN_BIT = 7;
	localparam int SAS_MODE_FR_LSB = 3;
	localparam int SAS_MODE_FR_W = 3;
	localparam logic [7:0] SAS_MODE_RST = 8'h00;
	localparam logic [7:0] SAS_MODE_MASK = 8'hB8;
	// channel select fields
	localparam int SAS_CHAN_W = 3;
	localparam logic [7:0] SAS_CHAN_RST = 8'h00;
	// conversion time codes and main-clock counts
	localparam logic [2:0] SAS_FR_144 = 3'h0;
	localparam logic [2:0] SAS_FR_120 = 3'h1;
	localparam logic [2:0] SAS_FR_96 = 3'h2;
	localparam logic [2:0] SAS_FR_72 = 3'h4;
	localparam logic [7:0] SAS_CYC_144 = 8'h90;
	localparam logic [7:0] SAS_CYC_120 = 8'h78;
	localparam logic [7:0] SAS_CYC_96 = 8'h60;
	localparam logic [7:0] SAS_CYC_72 = 8'h48;
	// fixed share of each conversion spent sampling; the rest is spread over 8 bit steps
	localparam logic [7:0] SAS_SAMPLE_CYC = 8'h08;
	localparam logic [7:0] SAS_TAP_HALF = 8'h80;
	typedef enum logic [1:0] {
		SAS_IDLE,
		SAS_SAMPLE,
		SAS_BITS
	} sas_state_t;
endpackage : sas_pkg

/* File: verification/sas_afe_model.sv */
`timescale 1ns/1ps
// analog front end: each channel has a fixed level, held while sample_hold is high
module sas_afe_model (
	// clock
	input wire logic clk,
	// converter side
	input wire logic [2:0] analog_sel,
	input wire logic sample_hold,
	input wire logic [7:0] tap_code,
	output logic comp_in
);
	logic [7:0] held;
	// top channel sits at full scale to hit the all-ones boundary
	function automatic logic [7:0] level(input logic [2:0] s);
		return (s == 3'h7) ? 8'hff : 8'h24 * {5'h00, s};
	endfunction : level
	// tracks the input only while sampling, like a real hold capacitor
	always_ff @(posedge clk) begin
		if (!sample_hold) begin
			held <= level(analog_sel);
		end
	end
	assign comp_in = (held >= tap_code);
endmodule : sas_afe_model

/* File: verification/sas_sequencer_tb_top.sv */
`timescale 1ns/1ps
module sas_sequencer_tb_top;
	import sas_pkg::*;
	logic clk, rst_n, reg_wr, reg_rd, standby, comp_in, res_valid, res_ready;
	logic conversion_end_irq, sample_hold;
	logic [15:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, tap_code, res_data, rd;
	logic [2:0] analog_sel;
	logic [2:0] fr [4] = '{SAS_FR_144, SAS_FR_120, SAS_FR_96, SAS_FR_72};
	int cy [4] = '{144, 120, 96, 72};
	int errors = 0, n_compared = 0, cyc = 0, n_irq = 0, t_irq = 0, t;
	////////////////////////////////////////////////////////////////////////////////
	sas_sequencer dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .standby(standby),
		.conversion_end_irq(conversion_end_irq), .analog_sel(analog_sel),
		.sample_hold(sample_hold), .tap_code(tap_code), .comp_in(comp_in),
		.res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
	sas_afe_model afe (.clk(clk), .analog_sel(analog_sel), .sample_hold(sample_hold),
		.tap_code(tap_code), .comp_in(comp_in));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (conversion_end_irq === 1'b1) begin
			n_irq <= n_irq + 1;
			t_irq <= cyc;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	// read data is registered, so it is looked at just after the edge that takes the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd_reg
	task automatic wait_irq(input int n);
		int k;
		k = n_irq + n;
		for (int i = 0; i < 4000 && n_irq < k; i++) begin
			@(posedge clk);
			#1;
		end
		check("irq count", 8'(n_irq), 8'(k));
	endtask : wait_irq
	task automatic quiet(input int n);
		int k;
		k = n_irq;
		repeat (n) @(posedge clk);
		#1 check("no irq", 8'(n_irq), 8'(k));
	endtask : quiet
	task automatic finish_test;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		errors++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 16'h0000;
		reg_wdata = 8'h00;
		standby = 1'b0;
		res_ready = 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(SAS_ADDR_MODE, rd);
		check("mode reset", rd, SAS_MODE_RST);
		rd_reg(SAS_ADDR_CHAN, rd);
		check("chan reset", rd, 8'h00);
		check("sel reset", {5'h00, analog_sel}, 8'h00);
		rd_reg(16'hff82, rd);
		check("unmapped", rd, 8'h00);
		quiet(300);
		wr(SAS_ADDR_CHAN, 8'h05);
		rd_reg(SAS_ADDR_CHAN, rd);
		check("chan", rd, 8'h05);
		check("sel", {5'h00, analog_sel}, 8'h05);
		wr(SAS_ADDR_CHAN, 8'h03);
		// first result after enable is discarded, as software must
		for (int i = 0; i < 4; i++) begin
			wr(SAS_ADDR_MODE, {2'b10, fr[i], 3'b000});
			wait_irq(1);
			wait_irq(1);
			t = t_irq;
			wait_irq(1);
			check("period", 8'(t_irq - t), 8'(cy[i]));
			rd_reg(SAS_ADDR_RESULT, rd);
			check("result", rd, 8'h6c);
		end
		// channel write mid-conversion restarts from the beginning
		wait_irq(1);
		repeat (30) @(posedge clk);
		wr(SAS_ADDR_CHAN, 8'h07);
		t = cyc;
		wait_irq(1);
		check("restart", 8'(t_irq - t >= 71 && t_irq - t <= 76), 8'h01);
		rd_reg(SAS_ADDR_RESULT, rd);
		check("new chan", rd, 8'hff);
		// stall the sink: only two words are kept
		@(posedge clk);
		res_ready <= 1'b0;
		wait_irq(3);
		wr(SAS_ADDR_MODE, 8'h00);
		quiet(200);
		for (int i = 0; i < 2; i++) begin
			check("res valid", {7'h00, res_valid}, 8'h01);
			check("res data", res_data, 8'hff);
			@(posedge clk);
			res_ready <= 1'b1;
			@(posedge clk);
			res_ready <= 1'b0;
			#1;
		end
		check("res empty", {7'h00, res_valid}, 8'h00);
		wr(SAS_ADDR_RESULT, 8'h00);
		rd_reg(SAS_ADDR_RESULT, rd);
		check("result ro", rd, 8'hff);
		wr(SAS_ADDR_MODE, 8'ha0);
		standby <= 1'b1;
		rd_reg(SAS_ADDR_MODE, rd);
		check("mode", rd, 8'ha0);
		quiet(300);
		// reset in mid-run, while converting, clears both registers and stops
		@(posedge clk);
		standby <= 1'b0;
		wait_irq(2);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(SAS_ADDR_MODE, rd);
		check("mode mid reset", rd, SAS_MODE_RST);
		rd_reg(SAS_ADDR_CHAN, rd);
		check("chan mid reset", rd, SAS_CHAN_RST);
		check("sel mid reset", {5'h00, analog_sel}, 8'h00);
		quiet(300);
		finish_test();
	end
endmodule : sas_sequencer_tb_top
